// *** dacsc_top.sv ***
// Serial control and readout of an 8-bit two-channel converter
// Assumes a mode-0 serial master; the analog front end gives a
// held sample word that stays stable while a conversion runs
`include "dacsc_regs.svh"
module dacsc_top
  import dacsc_pkg::*;
#(
  parameter int STEP_CYC = `DACSC_STEP_CYC, // Oscillator period, mclk cycles
  parameter int CONV_CYC = `DACSC_CONV_CYC  // Longest conversion, mclk cycles
) (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Serial link
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  output logic            dout,
  output logic            dout_oe,
  // Analog front end
  input  wire logic [7:0] held_code,
  output logic            track,
  output logic [2:0]      input_select,
  output logic            bipolar,
  output logic            reference_source_select,
  output logic            reference_power_down_n,
  output logic            device_power_down_n,
  output logic            conv_busy
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The counter must hold a step, and eight steps must
  // fit inside the longest allowed conversion time
  if (STEP_CYC < 2 || STEP_CYC >= (1 << `DACSC_CNT_W)
      || 8 * STEP_CYC > CONV_CYC) begin : g_bad
    $error("dacsc_top: oscillator step does not fit");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dacsc_link_if lk ();       // Core to output stage

  dacsc_rise_t  rr;          // Rising sclk state
  dacsc_rise_t  next_rr;     // Its next value
  dacsc_core_t  c;           // mclk state
  dacsc_core_t  next_c;      // Its next value

  logic         act_eff;     // Frame live and not fresh
  logic         may_start;   // A start bit is accepted
  logic [4:0]   k;           // Edge number after this one
  logic [2:0]   dec_idx;     // External decision bit
  logic [7:0]   trial;       // External trial code
  logic         rr_bip;      // Latched byte is bipolar
  logic [7:0]   rr_enc;      // External result, encoded
  logic [7:0]   c_trial;     // Internal trial code
  logic [7:0]   c_enc;       // Internal result, encoded
  logic         c_bip;       // Internal byte is bipolar
  logic         go_edge;     // New control byte arrived
  logic         dn_edge;     // External conversion ended

  // ----------------------------------------
  // Helper: bipolar configurations are 011, 010, 001
  // ----------------------------------------
  function automatic logic is_bip(input logic [2:0] sel);
    is_bip = !sel[2] && (sel != 3'h0);
  endfunction

  // ----------------------------------------
  // Link domain, rising sclk
  // ----------------------------------------
  // First rising edge of a frame sees seen low, so a
  // toggle of cs_n drops any half-done external work
  assign act_eff = rr.act && lk.seen;

  // New start bit only once the previous byte is used up;
  // in external mode this waits for the LSB to leave
  always_comb begin
    if (!act_eff) begin
      may_start = 1'b1;
    end else if (rr.ext) begin
      may_start = rr.ecnt >= `DACSC_E_SAT;
    end else begin
      may_start = rr.ecnt >= `DACSC_E_RE_INT;
    end
  end

  // Edge number this rising edge will become
  assign k = (rr.ecnt < `DACSC_E_SAT) ? 5'(rr.ecnt + `DACSC_E_ONE) : rr.ecnt;

  // Decision index: edge 7 decides bit 7, edge 14 bit 0
  assign dec_idx = 3'(`DACSC_E_DEC_LAST - k);
  assign trial   = rr.sar | (8'h01 << dec_idx);

  // Two's complement is offset binary with MSB flipped
  assign rr_bip = is_bip(rr.cfg[`DACSC_B_SEL_HI:`DACSC_B_SEL_LO]);
  assign rr_enc = rr_bip ? {~rr.sar[7], rr.sar[6:0]} : rr.sar;

  // Rising edge: control byte capture and external SAR
  always_comb begin
    next_rr = rr;
    if (cs_n) begin
      // Deselected: nothing is clocked in
      next_rr.act = rr.act;
    end else if (may_start) begin
      if (din) begin
        // First one is control bit 7
        next_rr.act  = 1'b1;
        next_rr.ecnt = `DACSC_E_ONE;
        next_rr.ctrl = `DACSC_CTRL_FIRST;
        next_rr.sar  = 8'h00;
      end else if (!act_eff) begin
        // Leading zeros have no effect
        next_rr.act  = 1'b0;
      end
    end else begin
      next_rr.ecnt = k;
      if (k <= `DACSC_E_CTRL_DONE) begin
        // Seven more bits follow the start bit
        next_rr.ctrl = {rr.ctrl[6:0], din};
      end
      if (k == `DACSC_E_CLKBIT) begin
        // Bit 3 arrives on edge 5
        next_rr.ext = din;
      end
      if (k == `DACSC_E_CTRL_DONE) begin
        // Whole byte in: hand it to the mclk side
        next_rr.cfg    = {rr.ctrl[6:0], din};
        next_rr.go_tgl = ~rr.go_tgl;
      end
      if (rr.ext && k >= `DACSC_E_DEC_FIRST && k <= `DACSC_E_DEC_LAST) begin
        // Each edge settles one bit of the result
        if (held_code >= trial) begin
          next_rr.sar = trial;
        end
        if (k == `DACSC_E_DEC_LAST) begin
          next_rr.done_tgl = ~rr.done_tgl;
        end
      end
    end
  end

  // Rising sclk register
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      rr <= '0;
    end else begin
      rr <= next_rr;
    end
  end

  // Values the output stage reads half a period later
  assign lk.ecnt = rr.ecnt;
  assign lk.act  = act_eff;
  assign lk.ext  = rr.ext;
  assign lk.enc  = rr_enc;

  // ----------------------------------------
  // Falling-edge output stage
  // ----------------------------------------
  dacsc_drv u_drv (
    .sclk    (sclk),
    .reset_n (reset_n),
    .cs_n    (cs_n),
    .lk      (lk)
  );

  // ----------------------------------------
  // mclk domain: crossings
  // ----------------------------------------
  // Toggles pass two flops; the word they announce was
  // stable well before, so it is read without a sync
  assign go_edge = c.go_s[1] ^ c.go_prev;
  assign dn_edge = c.dn_s[1] ^ c.dn_prev;

  // Internal trial and result coding
  assign c_trial = c.sar | (8'h01 << c.bit_idx);
  assign c_bip   = is_bip(c.ccfg[`DACSC_B_SEL_HI:`DACSC_B_SEL_LO]);
  assign c_enc   = c_bip ? {~c.sar[7], c.sar[6:0]} : c.sar;

  // ----------------------------------------
  // mclk domain: oscillator sequencer
  // ----------------------------------------
  always_comb begin
    next_c         = c;
    // Synchronisers
    next_c.go_s    = {c.go_s[0], rr.go_tgl};
    next_c.go_prev = c.go_s[1];
    next_c.dn_s    = {c.dn_s[0], rr.done_tgl};
    next_c.dn_prev = c.dn_s[1];
    next_c.h1      = held_code;
    next_c.h2      = c.h1;
    if (go_edge) begin
      // Configuration takes effect for the new conversion
      next_c.ccfg    = rr.cfg;
      next_c.sel     = rr.cfg[`DACSC_B_SEL_HI:`DACSC_B_SEL_LO];
      next_c.bip     = is_bip(rr.cfg[`DACSC_B_SEL_HI:`DACSC_B_SEL_LO]);
      next_c.ref_sel = rr.cfg[`DACSC_B_REF_SEL];
      next_c.busy    = 1'b1;
      next_c.msb     = 1'b0;
      next_c.sar     = 8'h00;
      next_c.bit_idx = 3'h7;
      next_c.cnt     = '0;
      if (!rr.cfg[`DACSC_B_CLK]) begin
        next_c.st = DACSC_CONV;
      end else begin
        next_c.st = DACSC_IDLE;
      end
    end else begin
      unique case (c.st)
        DACSC_IDLE: begin
          if (dn_edge) begin
            // External result done: power bits now apply
            next_c.busy   = 1'b0;
            next_c.dev_on = c.ccfg[`DACSC_B_DEV_ON];
            next_c.ref_on = c.ccfg[`DACSC_B_REF_ON]
                            & c.ccfg[`DACSC_B_REF_SEL];
          end
        end
        DACSC_CONV: begin
          // One decision per oscillator period
          if (c.cnt == `DACSC_CNT_W'(STEP_CYC - 1)) begin
            next_c.cnt = '0;
            if (c.h2 >= c_trial) begin
              next_c.sar = c_trial;
            end
            if (c.bit_idx == 3'h0) begin
              next_c.st = DACSC_IDLE;
            end else begin
              next_c.bit_idx = 3'(c.bit_idx - 3'h1);
            end
          end else begin
            next_c.cnt = `DACSC_CNT_W'(c.cnt + 1'b1);
          end
        end
      endcase
      // Result lands the cycle after the last decision
      if (c.st == DACSC_CONV && next_c.st == DACSC_IDLE) begin
        next_c.busy = 1'b0;
      end
      if (c.busy && !next_c.busy && c.st == DACSC_CONV) begin
        // Sar is updated next cycle; finish below
        next_c.busy = 1'b1;
      end
      if (c.st == DACSC_IDLE && c.busy && !c.ccfg[`DACSC_B_CLK]) begin
        // Internal result ready: MSB goes to the pin
        next_c.busy   = 1'b0;
        next_c.res    = c_enc;
        next_c.msb    = c_enc[7];
        next_c.dev_on = c.ccfg[`DACSC_B_DEV_ON];
        next_c.ref_on = c.ccfg[`DACSC_B_REF_ON]
                        & c.ccfg[`DACSC_B_REF_SEL];
      end
    end
  end

  // mclk register; power-up leaves reference and device off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // Internal result toward the output stage
  assign lk.res     = c.res;
  assign lk.int_msb = c.msb;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Serial pin and track come from the falling-edge stage;
  // the rest from mclk flops
  assign dout                    = lk.dout;
  assign dout_oe                 = lk.dout_oe;
  assign track                   = lk.track;
  assign input_select            = c.sel;
  assign bipolar                 = c.bip;
  assign reference_source_select = c.ref_sel;
  assign reference_power_down_n  = c.ref_on;
  assign device_power_down_n     = c.dev_on;
  assign conv_busy               = c.busy;

endmodule

// *** dacsc_regs.svh ***
// Constants of the dual-channel converter serial control block
// Assumes inclusion by bare name; the package holds the types
`ifndef DACSC_REGS_SVH
`define DACSC_REGS_SVH

// ----------------------------------------
// Control byte field positions
// ----------------------------------------
`define DACSC_B_SEL_HI    6
`define DACSC_B_SEL_LO    4
`define DACSC_B_CLK       3
`define DACSC_B_REF_SEL   2
`define DACSC_B_REF_ON    1
`define DACSC_B_DEV_ON    0
`define DACSC_CTRL_W      8
`define DACSC_CTRL_FIRST  8'h01

// ----------------------------------------
// Serial edge numbers, counted from the start bit
// ----------------------------------------
`define DACSC_ECNT_W      5
`define DACSC_E_ONE       5'h01
`define DACSC_E_TRACK     5'h04
`define DACSC_E_CLKBIT    5'h05
`define DACSC_E_HOLD_EXT  5'h06
`define DACSC_E_DEC_FIRST 5'h07
`define DACSC_E_CTRL_DONE 5'h08
`define DACSC_E_LAST_OUT  5'h0f
`define DACSC_E_DEC_LAST  5'h0e
`define DACSC_E_SAT       5'h10
`define DACSC_E_RE_INT    5'h09

// ----------------------------------------
// Timing
// ----------------------------------------
`define DACSC_MCLK_NS     25
`define DACSC_TOSC_NS     2500
`define DACSC_TCONV_NS    35000
`define DACSC_STEP_CYC    (`DACSC_TOSC_NS / `DACSC_MCLK_NS)
`define DACSC_CONV_CYC    (`DACSC_TCONV_NS / `DACSC_MCLK_NS)
`define DACSC_CNT_W       12

`endif

// *** dacsc_pkg.sv ***
// Types of the dual-channel converter serial control block
// Assumes the constants header sits beside this file
`include "dacsc_regs.svh"
package dacsc_pkg;

  // Internal oscillator sequencer
  typedef enum logic [0:0] {
    DACSC_IDLE = 1'b0,
    DACSC_CONV = 1'b1
  } dacsc_osc_st_t;

  // State clocked on rising serial clock
  typedef struct packed {
    logic                     act;
    logic [`DACSC_ECNT_W-1:0] ecnt;
    logic [7:0]               ctrl;
    logic [7:0]               cfg;
    logic [7:0]               sar;
    logic                     ext;
    logic                     go_tgl;
    logic                     done_tgl;
  } dacsc_rise_t;

  // State clocked on falling serial clock
  typedef struct packed {
    logic       seen;
    logic       oe;
    logic       d;
    logic       track;
    logic       wait_int;
    logic [7:0] sh;
  } dacsc_fall_t;

  // State clocked on mclk
  typedef struct packed {
    logic [1:0]             go_s;
    logic                   go_prev;
    logic [1:0]             dn_s;
    logic                   dn_prev;
    logic [7:0]             h1;
    logic [7:0]             h2;
    dacsc_osc_st_t          st;
    logic [`DACSC_CNT_W-1:0] cnt;
    logic [2:0]             bit_idx;
    logic [7:0]             sar;
    logic [7:0]             ccfg;
    logic [7:0]             res;
    logic                   msb;
    logic [2:0]             sel;
    logic                   bip;
    logic                   ref_sel;
    logic                   ref_on;
    logic                   dev_on;
    logic                   busy;
  } dacsc_core_t;

endpackage

// *** dacsc_link_if.sv ***
// Signals between the core and the falling-edge output stage
// Assumes both ends sit in one top module
interface dacsc_link_if;
  logic [4:0] ecnt;    // Edge count since start bit
  logic       act;     // Control byte or conversion live
  logic       ext;     // External clock mode latched
  logic [7:0] enc;     // External result, encoded
  logic [7:0] res;     // Internal result, encoded
  logic       int_msb; // Internal result MSB once ready
  logic       seen;    // A falling edge seen in this frame
  logic       dout;    // Serial output level
  logic       dout_oe; // Serial output enable
  logic       track;   // Track/hold in track mode
  modport core (output ecnt, act, ext, enc, res, int_msb,
                input  seen, dout, dout_oe, track);
  modport drv  (input  ecnt, act, ext, enc, res, int_msb,
                output seen, dout, dout_oe, track);
endinterface

// *** dacsc_drv.sv ***
// Falling-edge output stage of the serial link
// Assumes cs_n high clears it; sclk may stop outside frames
`include "dacsc_regs.svh"
module dacsc_drv
  import dacsc_pkg::*;
(
  // Link clock and frame
  input  wire logic sclk,
  input  wire logic reset_n,
  input  wire logic cs_n,
  // Core side
  dacsc_link_if.drv lk
);

  dacsc_fall_t r;      // Registered state
  dacsc_fall_t next_r; // Next state
  logic        clr;    // Frame end or reset

  // Deselect releases the pin at once, no edge needed
  assign clr = cs_n | ~reset_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r      = r;
    next_r.seen = 1'b1;
    next_r.oe   = 1'b1;
    // Track from edge 4, hold at 6 or 8 by mode
    if (lk.act && lk.ecnt == `DACSC_E_TRACK) begin
      next_r.track = 1'b1;
    end else if (lk.act && lk.ext && lk.ecnt == `DACSC_E_HOLD_EXT) begin
      next_r.track = 1'b0;
    end else if (lk.act && !lk.ext && lk.ecnt == `DACSC_E_CTRL_DONE) begin
      next_r.track = 1'b0;
    end
    if (r.wait_int) begin
      // First readout edge after the oscillator result
      next_r.wait_int = 1'b0;
      next_r.d        = lk.res[6];
      next_r.sh       = {lk.res[5:0], 2'b00};
    end else if (lk.act && !lk.ext && lk.ecnt == `DACSC_E_CTRL_DONE) begin
      next_r.wait_int = 1'b1;
      next_r.d        = 1'b0;
    end else if (lk.act && lk.ext && lk.ecnt >= `DACSC_E_CTRL_DONE
                 && lk.ecnt <= `DACSC_E_LAST_OUT) begin
      // MSB on edge 8, then one bit per edge
      next_r.d = lk.enc[~lk.ecnt[2:0]];
    end else begin
      // Remaining bits, then zeros until deselect
      next_r.d  = r.sh[7];
      next_r.sh = {r.sh[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Register, cleared while deselected
  // ----------------------------------------
  always_ff @(negedge sclk or posedge clr) begin
    if (clr) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Pin stays released until the first falling edge of the frame
  assign lk.dout    = r.wait_int ? lk.int_msb : r.d;
  assign lk.dout_oe = r.oe;
  assign lk.track   = r.track;
  assign lk.seen    = r.seen;

endmodule

// *** dacsc_host.sv ***
// Host model: a mode-0 serial master driving the converter link
// Assumes one caller at a time; link clock stands low between frames
module dacsc_host (
  // Serial master pins
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  // Device answer
  input  wire logic dout,
  input  wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bench time is scaled: one 48 ns period stands for a legal host period,
  // below 2MHz, and within 50kHz to 500kHz in external mode
  localparam int HALF_NS = 24; // Half of the 48 ns link period

  // Idle: deselected, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // ------------------------------
  // One frame: lead zeros, byte, 10 read clocks
  // ------------------------------
  // Pausing after the byte gives internal conversions their time
  task automatic frame(input logic [7:0] ctrl, input int lead, input int gap_ns,
                       output logic [7:0] rx);
    rx = 8'h00;
    #3 cs_n <= 1'b0;
    for (int i = 0; i < lead + 18; i++) begin
      din <= (i >= lead && i < lead + 8) ? ctrl[7 - (i - lead)] : 1'b0;
      #(HALF_NS) sclk <= 1'b1;
      // Released output reads as garbage, never as a held value
      if (i >= lead + 8 && i < lead + 16)
        rx = {rx[6:0], dout_oe ? dout : ~rx[0]};
      #(HALF_NS) sclk <= 1'b0;
      if (i == lead + 7)
        #(gap_ns);
    end
    #200 cs_n <= 1'b1;
    din <= 1'b1; // Noise while deselected
  endtask
endmodule

// *** dacsc_top_chk.sv ***
// Checker for the converter serial control block
// Assumes a bind onto dacsc_top; sees only its ports
module dacsc_top_chk #(
  parameter int STEP_CYC = 100, // Oscillator period, mclk cycles
  parameter int CONV_CYC = 1400 // Longest conversion, mclk cycles
) (
  // Clocks and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       sclk,
  // Serial link
  input wire logic       cs_n,
  input wire logic       din,
  input wire logic       dout,
  input wire logic       dout_oe,
  // Front end and status
  input wire logic [7:0] held_code,
  input wire logic       track,
  input wire logic [2:0] input_select,
  input wire logic       bipolar,
  input wire logic       reference_power_down_n,
  input wire logic       device_power_down_n,
  input wire logic       conv_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_MAX = CONV_CYC + 16; // Slack for the hand-over sync
  logic [15:0] busy_cyc; // Cycles busy has stood high, saturating
  logic [4:0] ecnt;     // Edges since start bit
  logic [7:0] cap;      // Control byte as shifted in
  logic [7:0] exp_code; // Result the byte should give

  // ------------------------------
  // Frame follower
  // ------------------------------
  // Cleared by cs_n high, as the device forgets a dropped frame
  always_ff @(posedge sclk or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      ecnt <= 5'h00;
      cap  <= 8'h00;
    end else if (ecnt != 5'h00 || din) begin
      if (ecnt != 5'h1f)
        ecnt <= ecnt + 5'h01;
      if (ecnt < 5'h08)
        cap <= {cap[6:0], din};
    end
  end
  assign exp_code = held_code ^ {(cap[6:4] inside {3'h1, 3'h2, 3'h3}), 7'h00};

  // ------------------------------
  // Link-domain checks
  // ------------------------------
  sequence s_byte_ext;
    ecnt == 5'h05 && cap[0];
  endsequence
  sequence s_byte_int;
    ecnt == 5'h05 && !cap[0];
  endsequence

  chk_dout_quiet: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n)
    ecnt inside {[5'h01:5'h07]} |-> dout_oe && !dout)
    else $error("serial output not low before result");
  chk_track_start: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n) ecnt == 5'h03 |-> !track ##1 track)
    else $error("tracking not begun at edge four");
  chk_track_ext: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n) s_byte_ext |-> track ##1 !track)
    else $error("external hold not at edge six");
  chk_track_int: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n) s_byte_int |-> track [*3] ##1 !track)
    else $error("internal hold not at edge eight");
  chk_result_order: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n)
    (ecnt >= 5'h08 && ecnt <= 5'h0f) |-> dout == exp_code[3'h7 - ecnt[2:0]])
    else $error("result bit wrong or out of order");
  chk_tail_zeros: assert property (
    @(posedge sclk) disable iff (!reset_n || cs_n) ecnt >= 5'h10 |-> !dout)
    else $error("output not zero after last bit");

  // ------------------------------
  // System-domain checks
  // ------------------------------
  // Counter instead of a delay range: the default bound is too long to unroll
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      busy_cyc <= 16'h0000;
    else if (!conv_busy)
      busy_cyc <= 16'h0000;
    else if (busy_cyc != 16'hffff)
      busy_cyc <= busy_cyc + 16'h0001;
  end

  chk_oe_released: assert property (
    @(posedge mclk) disable iff (!reset_n) cs_n |-> !dout_oe)
    else $error("output enabled while deselected");
  chk_start_needed: assert property (
    @(posedge mclk) disable iff (!reset_n) $rose(conv_busy) |-> ecnt >= 5'h08)
    else $error("conversion without a whole byte");
  chk_sel_update: assert property (
    @(posedge mclk) disable iff (!reset_n) $rose(conv_busy) |-> ##[0:4]
    (input_select == cap[6:4] && bipolar == (cap[6:4] inside {3'h1, 3'h2, 3'h3})))
    else $error("input configuration not applied");
  chk_busy_bound: assert property (
    @(posedge mclk) disable iff (!reset_n) busy_cyc <= BUSY_MAX)
    else $error("conversion overran its bound");
  chk_power_apply: assert property (
    @(posedge mclk) disable iff (!reset_n) $fell(conv_busy) |-> ##[0:2]
    (device_power_down_n == cap[0] && reference_power_down_n == (cap[1] & cap[2])))
    else $error("power bits not applied at end");
endmodule

// *** dacsc_top_tb.sv ***
// Self-checking bench of the converter serial control block
// Assumes host model and checker compile first
module dacsc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 32;                 // Short conversion ceiling
  localparam int GAP_NS = (CONV + 24) * 25; // Pause before internal readout
  logic       mclk;                    // System clock
  logic       reset_n;                 // Active-low reset
  logic       sclk;                    // Link clock
  logic       cs_n;                    // Chip select
  logic       din;                     // Serial in
  logic       dout;                    // Serial out
  logic       dout_oe;                 // Serial out enable
  logic [7:0] held_code;               // Held sample word
  logic       track;                   // Track/hold state
  logic [2:0] input_select;            // Input configuration
  logic       bipolar;                 // Bipolar coding
  logic       reference_source_select; // Reference source
  logic       reference_power_down_n;  // Reference powered
  logic       device_power_down_n;     // Device powered
  logic       conv_busy;               // Conversion running
  logic [7:0] last;                    // Last accepted control byte
  int         error_cnt = 0;
  int         checks_done = 0;
  int         cyc = 0;
  logic [2:0] lows [3] = '{3'h7, 3'h3, 3'h0};
  logic [7:0] codes [8] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h5a, 8'ha5, 8'h01, 8'hfe};

  dacsc_top #(.STEP_CYC(4), .CONV_CYC(CONV)) dacsc_top_inst (
    .mclk, .reset_n, .sclk, .cs_n, .din, .dout, .dout_oe, .held_code, .track,
    .input_select, .bipolar, .reference_source_select, .reference_power_down_n,
    .device_power_down_n, .conv_busy);
  dacsc_host dacsc_host_inst (.sclk, .cs_n, .din, .dout, .dout_oe);

  // Clock and hang guard
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      results();
    end
  end

  // ------------------------------
  // Compare and report
  // ------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [7:0] status();
    return {input_select, bipolar, reference_source_select, reference_power_down_n,
            device_power_down_n, dout_oe};
  endfunction
  function automatic logic [7:0] stat_of(input logic [7:0] c);
    return {c[6:4], (c[6:4] inside {3'h1, 3'h2, 3'h3}), c[2], c[2] & c[1], c[0], 1'b0};
  endfunction

  // One conversion; a byte without start bit must change nothing
  task automatic conv(input logic [7:0] c, input int lead, input int gap, input logic [7:0] code);
    logic [7:0] rx;
    @(posedge mclk);
    held_code <= code;
    dacsc_host_inst.frame(c, lead, gap, rx);
    repeat (3) @(posedge mclk);
    if (c[7])
      last = c;
    chk("result", c[7] ? code ^ {(c[6:4] inside {3'h1, 3'h2, 3'h3}), 7'h00} : 8'h00, rx);
    chk("status", stat_of(last), status());
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    reset_n = 1'b0;
    held_code = 8'h00;
    last = 8'h00;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk("status", 8'h00, status());
    // Every input configuration, external clock, power bits rotating
    for (int i = 0; i < 8; i++)
      conv({1'b1, 3'(i), 1'b1, lows[i % 3]}, i % 4, 0, codes[i]);
    conv(8'hb7, 1, GAP_NS, 8'h80);
    conv(8'hd3, 0, GAP_NS, 8'h3c);
    conv(8'h00, 0, 0, 8'h55);
    // Reset in mid-run, then work again
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("status", 8'h00, status());
    reset_n <= 1'b1;
    last = 8'h00;
    conv(8'hff, 2, 0, 8'hc3);
    results();
  end
endmodule

bind dacsc_top dacsc_top_chk #(.STEP_CYC(STEP_CYC), .CONV_CYC(CONV_CYC)) dacsc_top_chk_inst (
  .mclk, .reset_n, .sclk, .cs_n, .din, .dout, .dout_oe, .held_code, .track,
  .input_select, .bipolar, .reference_power_down_n, .device_power_down_n, .conv_busy);
